// File: inc/tsap_cfg.svh
// Constants for the transport adaptation header parser
`ifndef TSAP_CFG_SVH
`define TSAP_CFG_SVH
`define TSAP_SYNC_BYTE 8'h47
`define TSAP_STUFF_BYTE 8'hFF
`define TSAP_PKT_LEN 8'hBC
`define TSAP_AFC_RSVD 2'h0
`define TSAP_AFC_PAY 2'h1
`define TSAP_AFC_ADAPT 2'h2
`define TSAP_AFC_BOTH 2'h3
`define TSAP_FLAG_DISC 7
`define TSAP_FLAG_RAND 6
`define TSAP_FLAG_ESPRI 5
`define TSAP_FLAG_PCR 4
`define TSAP_FLAG_OPCR 3
`define TSAP_FLAG_SPLICE 2
`define TSAP_FLAG_PRIV 1
`define TSAP_FLAG_EXT 0
`define TSAP_CLKREF_BYTES 3'h6
`define TSAP_EXT_MAX 9'h12B
`define TSAP_PID_BITS 13
`define TSAP_CC_RESET 4'h0
`endif

// File: inc/tsap_pkg.sv
// Types for the transport adaptation header parser
package tsap_pkg;
  typedef enum logic [7:0] {
    ST_HUNT = 8'h01,
    ST_LINK = 8'h02,
    ST_ALEN = 8'h04,
    ST_FLAGS = 8'h08,
    ST_OPT = 8'h10,
    ST_STUFF = 8'h20,
    ST_PAY = 8'h40,
    ST_DROP = 8'h80
  } parse_state_e;
  typedef struct packed {
    logic [32:0] base;
    logic [8:0] ext;
  } clkref_s;
endpackage

// File: inc/tsap_cc_if.sv
// Continuity check request and result bundle
`timescale 1ns/1ns
interface tsap_cc_if;
  logic req;
  logic [12:0] pid;
  logic [3:0] cc;
  logic [1:0] afc;
  logic dup;
  logic gap;
  modport parser (output req, output pid, output cc, output afc, input dup, input gap);
  modport checker_side (input req, input pid, input cc, input afc, output dup, output gap);
endinterface

// File: hdl/tsap_cc_check.sv
// Continuity counter checker with a small table of tracked PIDs
`timescale 1ns/1ns
`include "tsap_cfg.svh"
module tsap_cc_check #(
  parameter int SLOTS = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  tsap_cc_if.checker_side cc
);
  import tsap_pkg::*;
  logic [12:0] pid_q [SLOTS];
  logic [3:0] last_q [SLOTS];
  logic [SLOTS-1:0] used_q;
  logic [$clog2(SLOTS)-1:0] vict_q;
  logic hit;
  logic [$clog2(SLOTS)-1:0] hit_idx;
  logic dup_q;
  logic gap_q;
  logic adv;

  always_comb begin
    hit = 1'b0;
    hit_idx = '0;
    for (int i = 0; i < SLOTS; i++) begin
      if (used_q[i] && pid_q[i] == cc.pid && !hit) begin
        hit = 1'b1;
        hit_idx = i[$clog2(SLOTS)-1:0];
      end
    end
  end

  // [R4] Advance expected only when the code carries payload
  assign adv = cc.afc[0];

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      used_q <= '0;
      vict_q <= '0;
      dup_q <= 1'b0;
      gap_q <= 1'b0;
      for (int i = 0; i < SLOTS; i++) begin
        pid_q[i] <= '0;
        last_q[i] <= `TSAP_CC_RESET;
      end
    end else begin
      dup_q <= 1'b0;
      gap_q <= 1'b0;
      if (cc.req) begin
        if (hit) begin
          // [R5] Duplicate packet detect
          if (adv && cc.cc == last_q[hit_idx]) begin
            dup_q <= 1'b1;
          // [R6] Gap against expected
          end else if (adv && cc.cc != last_q[hit_idx] + 4'h1) begin
            gap_q <= 1'b1;
          end else if (!adv && cc.cc != last_q[hit_idx]) begin
            gap_q <= 1'b1;
          end
          last_q[hit_idx] <= cc.cc;
        end else begin
          used_q[vict_q] <= 1'b1;
          pid_q[vict_q] <= cc.pid;
          last_q[vict_q] <= cc.cc;
          vict_q <= vict_q + 1'b1;
        end
      end
    end
  end
  assign cc.dup = dup_q;
  assign cc.gap = gap_q;
endmodule

// File: hdl/tsap_pcr_track.sv
// Local 27 MHz clock reference that re-phases on received PCR values
`timescale 1ns/1ns
`include "tsap_cfg.svh"
module tsap_pcr_track (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic tick_i,
  input wire logic load_i,
  input wire logic disc_i,
  input tsap_pkg::clkref_s pcr_i,
  output tsap_pkg::clkref_s local_o,
  output logic err_o
);
  import tsap_pkg::*;
  clkref_s loc_q;
  logic err_q;
  logic seen_q;

  // [R16] Extension wraps at 299
  function automatic clkref_s step(input clkref_s v);
    clkref_s r;
    r = v;
    if (v.ext >= `TSAP_EXT_MAX) begin
      r.ext = 9'h000;
      r.base = v.base + 33'h1;
    end else begin
      r.ext = v.ext + 9'h001;
    end
    return r;
  endfunction

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      loc_q <= '0;
      err_q <= 1'b0;
      seen_q <= 1'b0;
    end else begin
      err_q <= 1'b0;
      if (load_i) begin
        // [R12] Re-phase on discontinuity
        if (seen_q && !disc_i && pcr_i != loc_q) begin
          err_q <= 1'b1;
        end
        // [R17] Sync local clock
        loc_q <= pcr_i;
        seen_q <= 1'b1;
      end else if (tick_i) begin
        loc_q <= step(loc_q);
      end
    end
  end
  assign local_o = loc_q;
  assign err_o = err_q;
endmodule

// File: hdl/tsap_parser.sv
// Transport link header tail and adaptation header parser
//
// Function
// [R1] Decode two-bit adaptation control code
// [R2] Sender omits adaptation on PSI packets
// [R3] Sender advances counter per PID packet
// [R4] Counter holds on codes 00 and 10
// [R5] Equal counter with payload means duplicate
// [R6] Report counter gaps as lost packets
// [R7] Length counts following bytes with stuffing
// [R8] Stuffing bytes 0xFF discarded uninterpreted
// [R9] Length may skip to payload start
// [R10] Last five flags mark optional fields
// [R11] Optional fields parsed in flag order
// [R12] Discontinuity re-phases clock, no error
// [R13] Signal random access entry points
// [R14] Ignore elementary stream priority flag
// [R15] Sender sends PCR within 100 ms
// [R16] PCR is 33-bit base, 9-bit extension
// [R17] PCR marks arrival of base end
// [R18] PCR may be rewritten in transit
// [R19] OPCR passed through, not for decoding
// [R20] Find packet by 0x47 sync byte
// [R21] Events for reserved code, gap, duplicate
// [R22] Oversized length flags malformed, drops packet
`timescale 1ns/1ns
`include "tsap_cfg.svh"
module tsap_parser #(
  parameter int CC_SLOTS = 4
) (
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  input wire logic [7:0] DATA_I,
  input wire logic VALID_I,
  input wire logic TICK27_I,
  output logic [7:0] PAY_DATA_O,
  output logic PAY_VALID_O,
  output logic PAY_START_O,
  output logic [12:0] PID_O,
  output logic HDR_VALID_O,
  output logic [1:0] AFC_O,
  output logic DISC_O,
  output logic RAND_ACC_O,
  output logic PCR_VALID_O,
  output tsap_pkg::clkref_s PCR_O,
  output logic OPCR_VALID_O,
  output tsap_pkg::clkref_s OPCR_O,
  output tsap_pkg::clkref_s LOCAL_CLK_O,
  output logic PCR_ERR_O,
  output logic RSVD_AFC_O,
  output logic CC_GAP_O,
  output logic CC_DUP_O,
  output logic MALFORMED_O
);
  import tsap_pkg::*;
  tsap_cc_if cc_bus ();
  logic [7:0] d_s1_q, d_s2_q;
  logic v_s1_q, v_s2_q;
  logic t_s1_q, t_s2_q;
  parse_state_e state_q;
  logic [7:0] left_q;
  logic [7:0] alen_q;
  logic [2:0] hcnt_q;
  logic [7:0] flags_q;
  logic [2:0] ocnt_q;
  logic [47:0] ref_q;
  logic [12:0] pid_q;
  logic [1:0] afc_q;
  logic cc_req_q;
  logic [3:0] cc_q;
  logic pcr_load_q;
  clkref_s pcr_q;
  logic [7:0] pay_data_q;
  logic pay_valid_q, pay_start_q, first_pay_q;
  logic hdr_valid_q, disc_q, rand_q, pcr_valid_q, opcr_valid_q;
  clkref_s opcr_q;
  logic rsvd_q, mal_q;
  logic [7:0] b;
  logic bv;
  logic [4:0] pend;
  logic [47:0] ref_nx;

  // Pins come from the upstream device clock domain
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      d_s1_q <= 8'h00;
      d_s2_q <= 8'h00;
      v_s1_q <= 1'b0;
      v_s2_q <= 1'b0;
      t_s1_q <= 1'b0;
      t_s2_q <= 1'b0;
    end else begin
      d_s1_q <= DATA_I;
      d_s2_q <= d_s1_q;
      v_s1_q <= VALID_I;
      v_s2_q <= v_s1_q;
      t_s1_q <= TICK27_I;
      t_s2_q <= t_s1_q;
    end
  end
  assign b = d_s2_q;
  assign bv = v_s2_q;
  // [R11] Remaining optional fields in order
  assign pend = {flags_q[`TSAP_FLAG_PCR], flags_q[`TSAP_FLAG_OPCR], flags_q[`TSAP_FLAG_SPLICE],
                 flags_q[`TSAP_FLAG_PRIV], flags_q[`TSAP_FLAG_EXT]};
  assign ref_nx = {ref_q[39:0], b};

  // [R16] Unpack 33-bit base and 9-bit extension
  function automatic clkref_s unpack(input logic [47:0] r);
    clkref_s c;
    c.base = r[47:15];
    c.ext = r[8:0];
    return c;
  endfunction

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      state_q <= ST_HUNT;
      left_q <= 8'h00;
      alen_q <= 8'h00;
      hcnt_q <= 3'h0;
      flags_q <= 8'h00;
      ocnt_q <= 3'h0;
      ref_q <= '0;
      pid_q <= '0;
      afc_q <= 2'h0;
      cc_q <= 4'h0;
    end else if (bv) begin
      left_q <= left_q - 8'h01;
      case (state_q)
        ST_HUNT: begin
          // [R20] Lock on sync byte
          if (b == `TSAP_SYNC_BYTE) begin
            state_q <= ST_LINK;
            hcnt_q <= 3'h0;
            left_q <= `TSAP_PKT_LEN - 8'h02;
          end
        end
        ST_LINK: begin
          hcnt_q <= hcnt_q + 3'h1;
          if (hcnt_q == 3'h0) begin
            pid_q[12:8] <= b[4:0];
          end else if (hcnt_q == 3'h1) begin
            pid_q[7:0] <= b;
          end else begin
            afc_q <= b[5:4];
            cc_q <= b[3:0];
            // [R1] Adaptation control decode
            case (b[5:4])
              `TSAP_AFC_PAY: state_q <= ST_PAY;
              `TSAP_AFC_ADAPT, `TSAP_AFC_BOTH: state_q <= ST_ALEN;
              default: state_q <= ST_DROP;
            endcase
          end
        end
        ST_ALEN: begin
          alen_q <= b;
          flags_q <= 8'h00;
          // [R22] Length beyond packet end
          if (b > left_q) begin
            state_q <= ST_DROP;
          end else if (b == 8'h00) begin
            state_q <= afc_q[0] ? ST_PAY : ST_DROP;
          end else begin
            state_q <= ST_FLAGS;
          end
        end
        ST_FLAGS: begin
          // [R10] Presence flags captured
          flags_q <= b;
          alen_q <= alen_q - 8'h01;
          ocnt_q <= 3'h0;
          // [R7] [R9] Length runs to payload
          if (alen_q == 8'h01) begin
            state_q <= afc_q[0] ? ST_PAY : ST_DROP;
          end else begin
            state_q <= ST_OPT;
          end
        end
        ST_OPT: begin
          alen_q <= alen_q - 8'h01;
          ocnt_q <= ocnt_q + 3'h1;
          ref_q <= ref_nx;
          if (pend[4] || pend[3]) begin
            if (ocnt_q == `TSAP_CLKREF_BYTES - 3'h1) begin
              ocnt_q <= 3'h0;
              if (pend[4]) begin
                flags_q[`TSAP_FLAG_PCR] <= 1'b0;
              end else begin
                flags_q[`TSAP_FLAG_OPCR] <= 1'b0;
              end
            end
          end else begin
            // Splice, private and extension fields are skipped as one run
            flags_q[2:0] <= 3'h0;
          end
          if (alen_q == 8'h01) begin
            state_q <= afc_q[0] ? ST_PAY : ST_DROP;
          end else if (!(pend[4] || pend[3]) && !(|pend[2:0])) begin
            state_q <= ST_STUFF;
          end
        end
        ST_STUFF: begin
          // [R8] Stuffing consumed unread
          alen_q <= alen_q - 8'h01;
          if (alen_q == 8'h01) begin
            state_q <= afc_q[0] ? ST_PAY : ST_DROP;
          end
        end
        ST_PAY, ST_DROP: begin
          // Left only by the packet end check below
        end
        default: state_q <= ST_HUNT;
      endcase
      // A header that runs to the last byte must not swallow the next sync
      if (state_q != ST_HUNT && left_q == 8'h00) begin
        state_q <= ST_HUNT;
      end
    end
  end

  // Status and link header outputs
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      hdr_valid_q <= 1'b0;
      cc_req_q <= 1'b0;
      rsvd_q <= 1'b0;
      mal_q <= 1'b0;
      disc_q <= 1'b0;
      rand_q <= 1'b0;
    end else begin
      hdr_valid_q <= 1'b0;
      cc_req_q <= 1'b0;
      rsvd_q <= 1'b0;
      mal_q <= 1'b0;
      if (bv && state_q == ST_LINK && hcnt_q == 3'h2) begin
        hdr_valid_q <= 1'b1;
        cc_req_q <= 1'b1;
        disc_q <= 1'b0;
        rand_q <= 1'b0;
        // [R21] Reserved code event
        rsvd_q <= (b[5:4] == `TSAP_AFC_RSVD);
      end
      if (bv && state_q == ST_ALEN && b > left_q) begin
        mal_q <= 1'b1;
      end
      if (bv && state_q == ST_FLAGS) begin
        disc_q <= b[`TSAP_FLAG_DISC];
        // [R13] Random access marker
        rand_q <= b[`TSAP_FLAG_RAND];
        // [R14] Priority flag unused
      end
    end
  end

  // [R18] Capture whatever value arrives
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      pcr_valid_q <= 1'b0;
      opcr_valid_q <= 1'b0;
      pcr_load_q <= 1'b0;
      pcr_q <= '0;
      opcr_q <= '0;
    end else begin
      pcr_valid_q <= 1'b0;
      opcr_valid_q <= 1'b0;
      pcr_load_q <= 1'b0;
      if (bv && state_q == ST_OPT && ocnt_q == `TSAP_CLKREF_BYTES - 3'h1) begin
        if (pend[4]) begin
          pcr_valid_q <= 1'b1;
          pcr_load_q <= 1'b1;
          pcr_q <= unpack(ref_nx);
        end else if (pend[3]) begin
          // [R19] OPCR forwarded only
          opcr_valid_q <= 1'b1;
          opcr_q <= unpack(ref_nx);
        end
      end
    end
  end

  // Payload forwarding
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      pay_data_q <= 8'h00;
      pay_valid_q <= 1'b0;
      pay_start_q <= 1'b0;
      first_pay_q <= 1'b0;
    end else begin
      pay_valid_q <= 1'b0;
      pay_start_q <= 1'b0;
      if (bv && state_q == ST_LINK) begin
        first_pay_q <= 1'b1;
      end
      if (bv && state_q == ST_PAY) begin
        pay_data_q <= b;
        pay_valid_q <= 1'b1;
        pay_start_q <= first_pay_q;
        first_pay_q <= 1'b0;
      end
    end
  end

  assign cc_bus.req = cc_req_q;
  assign cc_bus.pid = pid_q;
  assign cc_bus.cc = cc_q;
  assign cc_bus.afc = afc_q;

  tsap_cc_check #(
    .SLOTS(CC_SLOTS)
  ) u_cc (
    .clk_i(CLK_SYS_I),
    .rst_i(RST_I),
    .cc(cc_bus)
  );

  tsap_pcr_track u_pcr (
    .clk_i(CLK_SYS_I),
    .rst_i(RST_I),
    .tick_i(t_s2_q),
    .load_i(pcr_load_q),
    .disc_i(disc_q),
    .pcr_i(pcr_q),
    .local_o(LOCAL_CLK_O),
    .err_o(PCR_ERR_O)
  );

  assign PAY_DATA_O = pay_data_q;
  assign PAY_VALID_O = pay_valid_q;
  assign PAY_START_O = pay_start_q;
  assign PID_O = pid_q;
  assign HDR_VALID_O = hdr_valid_q;
  assign AFC_O = afc_q;
  assign DISC_O = disc_q;
  assign RAND_ACC_O = rand_q;
  assign PCR_VALID_O = pcr_valid_q;
  assign PCR_O = pcr_q;
  assign OPCR_VALID_O = opcr_valid_q;
  assign OPCR_O = opcr_q;
  assign RSVD_AFC_O = rsvd_q;
  // [R21] Gap and duplicate events
  assign CC_GAP_O = cc_bus.gap;
  assign CC_DUP_O = cc_bus.dup;
  assign MALFORMED_O = mal_q;
endmodule

// File: sim/tsap_parser_sva.sv
// Port-level checks for the adaptation header parser
`timescale 1ns/1ns
module tsap_parser_sva (
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  input wire logic PAY_VALID_O,
  input wire logic PAY_START_O,
  input wire logic HDR_VALID_O,
  input wire logic [1:0] AFC_O,
  input wire logic DISC_O,
  input wire logic PCR_VALID_O,
  input tsap_pkg::clkref_s LOCAL_CLK_O,
  input wire logic PCR_ERR_O,
  input wire logic RSVD_AFC_O,
  input wire logic CC_GAP_O,
  input wire logic CC_DUP_O,
  input wire logic MALFORMED_O
);
  import tsap_pkg::*;
  logic [2:0] pv_q;
  logic quiet;
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      pv_q <= 3'h0;
    end else begin
      pv_q <= {pv_q[1:0], PCR_VALID_O};
    end
  end
  // A received reference may move the local clock anywhere, so steps near a load are not judged
  assign quiet = !PCR_VALID_O && pv_q == 3'h0;
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (RST_I);
  a_start_has_byte: assert property (PAY_START_O |-> PAY_VALID_O)
    else $error("payload start without byte");
  a_pay_code: assert property (PAY_VALID_O |-> AFC_O[0])
    else $error("payload under a code without payload");
  a_rsvd_code: assert property (RSVD_AFC_O |-> AFC_O == 2'h0)
    else $error("reserved event on other code");
  a_mal_drop: assert property (MALFORMED_O |=> !PAY_VALID_O [*8])
    else $error("payload after malformed header");
  a_cc_timing: assert property ((CC_GAP_O || CC_DUP_O) |-> $past(HDR_VALID_O))
    else $error("counter event not after header");
  a_dup_payload: assert property (CC_DUP_O |-> AFC_O[0] && !CC_GAP_O)
    else $error("duplicate on code without payload");
  a_err_disc: assert property (PCR_ERR_O |-> !DISC_O)
    else $error("clock error despite discontinuity");
  a_ext_range: assert property (LOCAL_CLK_O.ext <= 9'h12B)
    else $error("extension out of range");
  a_ext_step: assert property ($changed(LOCAL_CLK_O) && quiet && $past(LOCAL_CLK_O.ext) != 9'h12B
    |-> LOCAL_CLK_O.ext == $past(LOCAL_CLK_O.ext) + 9'h1 && $stable(LOCAL_CLK_O.base))
    else $error("local clock bad step");
  a_ext_wrap: assert property ($changed(LOCAL_CLK_O) && quiet && $past(LOCAL_CLK_O.ext) == 9'h12B
    |-> LOCAL_CLK_O.ext == 9'h0 && LOCAL_CLK_O.base == $past(LOCAL_CLK_O.base) + 33'h1)
    else $error("local clock bad wrap");
  c_payload: cover property (PAY_START_O);
  c_dup: cover property (CC_DUP_O);
  c_wrap: cover property ($past(LOCAL_CLK_O.ext) == 9'h12B && LOCAL_CLK_O.ext == 9'h0);
endmodule

// File: sim/tsap_pkt_src.sv
// Packet source standing for the upstream multiplexer
`timescale 1ns/1ns
module tsap_pkt_src (
  input wire logic clk_i,
  output logic [7:0] data_o,
  output logic valid_o
);
  import tsap_pkg::*;
  logic [7:0] mem [188];
  initial begin
    data_o = 8'h00;
    valid_o = 1'b0;
  end
  task automatic put(inout int k, input clkref_s v);
    logic [47:0] w;
    w = {v.base, 6'h3F, v.ext};
    for (int j = 5; j >= 0; j--) begin
      mem[k] = w[j*8 +: 8];
      k++;
    end
  endtask
  // Tables are never sent here, so no adaptation header rides on them
  // Sender side
  task automatic build(input logic [12:0] pid, input logic [1:0] afc, input logic [3:0] cc,
    input logic [7:0] alen, input logic [7:0] flg, input clkref_s pcr);
    int k;
    for (int i = 0; i < 188; i++) mem[i] = i[7:0];
    mem[0] = 8'h47;
    mem[1] = {3'h0, pid[12:8]};
    mem[2] = pid[7:0];
    mem[3] = {2'h0, afc, cc};
    if (afc[1]) begin
      mem[4] = alen;
      // A zero length carries no flag byte, so byte 5 stays payload
      if (alen != 8'h00) mem[5] = flg;
      k = 6;
      for (int i = 6; i < 5 + alen && i < 188; i++) mem[i] = 8'hFF;
      if (flg[4]) put(k, pcr);
      if (flg[3]) put(k, {~pcr.base, pcr.ext});
    end
  endtask
  // Idle cycles carry junk; with a gap the closing idle cycle repeats the last byte
  task automatic send(input int junk, input int gap);
    repeat (junk) begin
      @(posedge clk_i);
      #1;
      data_o = 8'h12;
      valid_o = 1'b1;
    end
    for (int i = 0; i < 188; i++) begin
      @(posedge clk_i);
      #1;
      data_o = mem[i];
      valid_o = 1'b1;
      repeat (gap) begin
        @(posedge clk_i);
        #1;
        valid_o = 1'b0;
        data_o = ~mem[i];
      end
    end
    @(posedge clk_i);
    #1;
    valid_o = 1'b0;
    data_o = ~data_o;
  endtask
endmodule

// File: sim/tb_tsap_parser.sv
// Self-checking bench for the adaptation header parser
`timescale 1ns/1ns
module tb_tsap_parser;
  import tsap_pkg::*;
  logic CLK_SYS_I, RST_I, VALID_I, TICK27_I, PAY_VALID_O, PAY_START_O, HDR_VALID_O, DISC_O, RAND_ACC_O;
  logic PCR_VALID_O, OPCR_VALID_O, PCR_ERR_O, RSVD_AFC_O, CC_GAP_O, CC_DUP_O, MALFORMED_O;
  logic [7:0] DATA_I, PAY_DATA_O, first_pay, last_pay;
  logic [12:0] PID_O;
  logic [1:0] AFC_O, tk;
  clkref_s PCR_O, OPCR_O, LOCAL_CLK_O;
  int num_errors, samples_checked, n_pay, n_hdr, n_rsvd, n_gap, n_dup, n_mal, n_err, n_opcr;
  tsap_pkt_src src (.clk_i(CLK_SYS_I), .data_o(DATA_I), .valid_o(VALID_I));
  tsap_parser #(.CC_SLOTS(4)) DUT (.CLK_SYS_I, .RST_I, .DATA_I, .VALID_I, .TICK27_I, .PAY_DATA_O, .PAY_VALID_O,
    .PAY_START_O, .PID_O, .HDR_VALID_O, .AFC_O, .DISC_O, .RAND_ACC_O, .PCR_VALID_O, .PCR_O, .OPCR_VALID_O,
    .OPCR_O, .LOCAL_CLK_O, .PCR_ERR_O, .RSVD_AFC_O, .CC_GAP_O, .CC_DUP_O, .MALFORMED_O);
  initial begin
    CLK_SYS_I = 1'b0;
    forever #5 CLK_SYS_I = ~CLK_SYS_I;
  end
  // Tick every fourth cycle, inside the allowed rate
  always @(posedge CLK_SYS_I) begin
    tk <= tk + 2'h1;
    TICK27_I <= #1 (tk == 2'h0);
  end
  // Sampled mid-cycle, where the flop outputs have settled
  always @(negedge CLK_SYS_I) begin
    if (PAY_VALID_O === 1'b1) begin
      n_pay++;
      last_pay = PAY_DATA_O;
    end
    if (PAY_START_O === 1'b1) first_pay = PAY_DATA_O;
    if (OPCR_VALID_O === 1'b1) n_opcr++;
    if (HDR_VALID_O === 1'b1) n_hdr++;
    if (RSVD_AFC_O === 1'b1) n_rsvd++;
    if (CC_GAP_O === 1'b1) n_gap++;
    if (CC_DUP_O === 1'b1) n_dup++;
    if (MALFORMED_O === 1'b1) n_mal++;
    if (PCR_ERR_O === 1'b1) n_err++;
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic pkt(input logic [12:0] pid, input logic [1:0] afc, input logic [3:0] cc, input logic [7:0] alen,
    input logic [7:0] flg, input clkref_s pcr, input int gap);
    {n_pay, n_hdr, n_rsvd, n_gap, n_dup, n_mal, n_err, n_opcr} = '0;
    src.build(pid, afc, cc, alen, flg, pcr);
    src.send(3, gap);
    repeat (8) @(posedge CLK_SYS_I);
  endtask
  task automatic t_payload();
    for (int g = 0; g < 2; g++) begin
      pkt(13'h101, 2'h1, g[3:0], 8'h00, 8'h00, '0, g);
      chk(n_hdr, 1);
      chk(PID_O, 13'h101);
      chk(AFC_O, 2'h1);
      chk(n_pay, 184);
      chk(first_pay, 8'h04);
      chk(last_pay, 8'hBB);
      chk(n_gap + n_dup, 0);
    end
  endtask
  task automatic t_adapt();
    clkref_s p;
    p = {33'h1_2345_6789, 9'h12A};
    // Splice flag set too: its byte is skipped with the stuffing
    pkt(13'h102, 2'h3, 4'h0, 8'h14, 8'h7C, p, 0);
    chk(PCR_O, p);
    chk(OPCR_O, {~p.base, p.ext});
    chk(n_opcr, 1);
    chk(RAND_ACC_O, 1'b1);
    chk(DISC_O, 1'b0);
    chk(n_pay, 163);
    chk(first_pay, 8'h19);
    chk(n_err, 0);
    pkt(13'h102, 2'h3, 4'h1, 8'h00, 8'h00, p, 0);
    chk(n_pay, 183);
    chk(first_pay, 8'h05);
  endtask
  task automatic t_codes();
    pkt(13'h103, 2'h0, 4'h0, 8'h00, 8'h00, '0, 0);
    chk(n_rsvd, 1);
    chk(n_pay, 0);
    pkt(13'h103, 2'h2, 4'h0, 8'hB7, 8'h00, '0, 0);
    chk(AFC_O, 2'h2);
    chk(n_pay + n_rsvd + n_gap, 0);
  endtask
  task automatic t_cc();
    logic [1:0] a [5] = '{2'h1, 2'h1, 2'h1, 2'h2, 2'h1};
    logic [3:0] c [5] = '{4'h5, 4'h5, 4'h6, 4'h6, 4'h8};
    int ev [5] = '{0, 1, 0, 0, 2};
    for (int i = 0; i < 5; i++) begin
      pkt(13'h104, a[i], c[i], 8'hB7, 8'h00, '0, 0);
      chk(n_gap * 2 + n_dup, ev[i]);
    end
  endtask
  task automatic t_pcr();
    pkt(13'h105, 2'h3, 4'h0, 8'hC8, 8'h00, '0, 0);
    chk(n_mal, 1);
    chk(n_pay, 0);
    pkt(13'h102, 2'h2, 4'h1, 8'hB7, 8'h10, {33'h0_0000_0100, 9'h000}, 1);
    chk(n_err, 1);
    pkt(13'h102, 2'h2, 4'h1, 8'hB7, 8'h90, {33'h0_0000_0200, 9'h000}, 0);
    chk(DISC_O, 1'b1);
    chk(n_err, 0);
    chk(PCR_O.base, 33'h200);
    // Under 299 ticks since the load, so the base has not moved yet
    chk(LOCAL_CLK_O.base, 33'h200);
  endtask
  initial begin
    RST_I = 1'b1;
    TICK27_I = 1'b0;
    tk = 2'h0;
    repeat (4) @(posedge CLK_SYS_I);
    #1;
    RST_I = 1'b0;
    t_payload();
    t_adapt();
    t_codes();
    t_cc();
    t_pcr();
    end_sim();
  end
  initial begin
    repeat (20000) @(posedge CLK_SYS_I);
    num_errors++;
    end_sim();
  end
endmodule
bind tsap_parser tsap_parser_sva u_sva (.CLK_SYS_I, .RST_I, .PAY_VALID_O, .PAY_START_O, .HDR_VALID_O, .AFC_O,
  .DISC_O, .PCR_VALID_O, .LOCAL_CLK_O, .PCR_ERR_O, .RSVD_AFC_O, .CC_GAP_O, .CC_DUP_O, .MALFORMED_O);
